// File: inc/cwg_pkg.sv
// shared constants of the command write guard
package cwg_pkg;
   localparam int          WORD_W  = 16;
   localparam int          CODE_W  = 8;
   localparam int          GUARD_N = 10;

   // lock bit positions within the fine write lock word
   localparam int          GUARD_SAVE_ALL     = 0;
   localparam int          GUARD_KEY          = 1;
   localparam int          GUARD_ADDR_SELECT  = 2;
   localparam int          GUARD_IDENT_TEXT   = 3;
   localparam int          GUARD_POWER_TIMING = 4;
   localparam int          GUARD_SUPPLY_LIMIT = 5;
   localparam int          GUARD_CONFIG       = 6;
   localparam int          GUARD_RUN_COMMAND  = 7;
   localparam int          GUARD_LEVEL_SHIFT  = 8;
   localparam int          GUARD_FAULT_LIMIT  = 9;

   // command codes of the serial management set
   localparam logic [7:0]  CMD_PAGE            = 8'h00;
   localparam logic [7:0]  CMD_OPERATION       = 8'h01;
   localparam logic [7:0]  CMD_ON_OFF_CONFIG   = 8'h02;
   localparam logic [7:0]  CMD_WRITE_PROTECT   = 8'h10;
   localparam logic [7:0]  CMD_STORE_ALL       = 8'h15;
   localparam logic [7:0]  CMD_OUT_COMMAND     = 8'h21;
   localparam logic [7:0]  CMD_MARGIN_HIGH     = 8'h25;
   localparam logic [7:0]  CMD_MARGIN_LOW      = 8'h26;
   localparam logic [7:0]  CMD_TRANSITION_RATE = 8'h27;
   localparam logic [7:0]  CMD_FREQ_SWITCH     = 8'h33;
   localparam logic [7:0]  CMD_SUPPLY_ON_LVL   = 8'h35;
   localparam logic [7:0]  CMD_SUPPLY_OFF_LVL  = 8'h36;
   localparam logic [7:0]  CMD_INTERLEAVE      = 8'h37;
   localparam logic [7:0]  CMD_OC_FAULT_LIMIT  = 8'h46;
   localparam logic [7:0]  CMD_OC_FAULT_RESP   = 8'h47;
   localparam logic [7:0]  CMD_OT_FAULT_LIMIT  = 8'h4F;
   localparam logic [7:0]  CMD_OT_FAULT_RESP   = 8'h50;
   localparam logic [7:0]  CMD_IN_OV_FAULT_LIM = 8'h55;
   localparam logic [7:0]  CMD_IN_OV_FAULT_RSP = 8'h56;
   localparam logic [7:0]  CMD_IN_OV_WARN_LIM  = 8'h57;
   localparam logic [7:0]  CMD_IN_UV_WARN_LIM  = 8'h58;
   localparam logic [7:0]  CMD_TON_DELAY       = 8'h60;
   localparam logic [7:0]  CMD_TON_RISE        = 8'h61;
   localparam logic [7:0]  CMD_TON_MAX_LIMIT   = 8'h62;
   localparam logic [7:0]  CMD_TON_MAX_RESP    = 8'h63;
   localparam logic [7:0]  CMD_TOFF_DELAY      = 8'h64;
   localparam logic [7:0]  CMD_TOFF_FALL       = 8'h65;
   localparam logic [7:0]  CMD_MAKER_ID        = 8'h99;
   localparam logic [7:0]  CMD_MAKER_MODEL     = 8'h9A;
   localparam logic [7:0]  CMD_MAKER_REVISION  = 8'h9B;
   localparam logic [7:0]  CMD_MAKER_SERIAL    = 8'h9E;
   localparam logic [7:0]  CMD_SIMULATE_FAULTS = 8'hD0;
   localparam logic [7:0]  CMD_COMP_CONFIG     = 8'hD1;
   localparam logic [7:0]  CMD_TRANSIENT_CFG   = 8'hD2;
   localparam logic [7:0]  CMD_TELEMETRY_CFG   = 8'hD3;
   localparam logic [7:0]  CMD_POWER_STAGE_CFG = 8'hD4;
   localparam logic [7:0]  CMD_PGOOD_CFG       = 8'hD5;
   localparam logic [7:0]  CMD_SYNC_CFG        = 8'hD6;
   localparam logic [7:0]  CMD_MISC_OPTIONS    = 8'hD7;
   localparam logic [7:0]  CMD_STACK_CFG       = 8'hD8;
   localparam logic [7:0]  CMD_PIN_DETECT_OVR  = 8'hD9;
   localparam logic [7:0]  CMD_BUS_ADDRESS     = 8'hDA;
   localparam logic [7:0]  CMD_KEY             = 8'hFA;
   localparam logic [7:0]  CMD_FINE_LOCK       = 8'hFB;
   localparam logic [7:0]  CMD_PLATFORM_IDENT  = 8'hFC;

   // standard write protect settings
   localparam logic [7:0]  WP_ALL_BUT_WP       = 8'h80;
   localparam logic [7:0]  WP_ALL_BUT_RUN      = 8'h40;
   localparam logic [7:0]  WP_ALL_BUT_LEVEL    = 8'h20;

   // platform ident value is arbitrary
   localparam logic [15:0] IDENT_VALUE         = 16'h5A3C;
   localparam logic [15:0] KEY_OPEN_VALUE      = 16'h0000;
   localparam logic [15:0] WORD_RESET          = 16'h0000;
   localparam logic [9:0]  GROUP_RESET         = 10'h000;

   typedef enum logic [1:0] {
      KEY_OPEN   = 2'b00,
      KEY_SHUT   = 2'b01,
      KEY_SEALED = 2'b11
   } cwg_key_state_t;
endpackage : cwg_pkg

// File: inc/cwg_class_if.sv
`timescale 1ns/100ps
`default_nettype none
// command code in, group and special-command flags out
interface cwg_class_if;
   import cwg_pkg::*;
   logic [CODE_W-1:0]  code;
   logic [GUARD_N-1:0] grp;
   logic               is_fine_lock;
   logic               is_key;
   logic               is_save_all;
   logic               is_ident;

   modport asker  (output code, input grp, is_fine_lock, is_key, is_save_all, is_ident);
   modport sorter (input code, output grp, is_fine_lock, is_key, is_save_all, is_ident);
endinterface : cwg_class_if
`default_nettype wire

// File: rtl/cwg_classify.sv
`timescale 1ns/100ps
`default_nettype none
module cwg_classify (
   cwg_class_if.sorter cls
);
   import cwg_pkg::*;

   always_comb begin
      cls.grp          = GROUP_RESET;
      cls.is_fine_lock = (cls.code == CMD_FINE_LOCK);
      cls.is_key       = (cls.code == CMD_KEY);
      cls.is_save_all  = (cls.code == CMD_STORE_ALL);
      cls.is_ident     = (cls.code == CMD_PLATFORM_IDENT);
      case (cls.code)
         CMD_OC_FAULT_LIMIT, CMD_OC_FAULT_RESP, CMD_OT_FAULT_LIMIT,
         CMD_OT_FAULT_RESP, CMD_SIMULATE_FAULTS: begin
            cls.grp[GUARD_FAULT_LIMIT] = 1'b1;
         end
         CMD_MARGIN_HIGH, CMD_MARGIN_LOW, CMD_TRANSITION_RATE: begin
            cls.grp[GUARD_LEVEL_SHIFT] = 1'b1;
         end
         CMD_OPERATION: begin
            cls.grp[GUARD_RUN_COMMAND] = 1'b1;
         end
         CMD_FREQ_SWITCH, CMD_INTERLEAVE, CMD_COMP_CONFIG, CMD_TRANSIENT_CFG,
         CMD_TELEMETRY_CFG, CMD_POWER_STAGE_CFG, CMD_PGOOD_CFG, CMD_SYNC_CFG,
         CMD_MISC_OPTIONS, CMD_STACK_CFG: begin
            cls.grp[GUARD_CONFIG] = 1'b1;
         end
         CMD_IN_UV_WARN_LIM, CMD_IN_OV_FAULT_LIM, CMD_IN_OV_WARN_LIM, CMD_IN_OV_FAULT_RSP: begin
            cls.grp[GUARD_SUPPLY_LIMIT] = 1'b1;
         end
         CMD_TON_DELAY, CMD_TON_RISE, CMD_TON_MAX_LIMIT, CMD_TON_MAX_RESP, CMD_TOFF_DELAY,
         CMD_TOFF_FALL, CMD_ON_OFF_CONFIG, CMD_SUPPLY_ON_LVL, CMD_SUPPLY_OFF_LVL: begin
            cls.grp[GUARD_POWER_TIMING] = 1'b1;
         end
         CMD_MAKER_ID, CMD_MAKER_MODEL, CMD_MAKER_REVISION, CMD_MAKER_SERIAL: begin
            cls.grp[GUARD_IDENT_TEXT] = 1'b1;
         end
         CMD_PIN_DETECT_OVR, CMD_BUS_ADDRESS: begin
            cls.grp[GUARD_ADDR_SELECT] = 1'b1;
         end
         CMD_KEY: begin
            cls.grp[GUARD_KEY] = 1'b1;
         end
         CMD_STORE_ALL: begin
            cls.grp[GUARD_SAVE_ALL] = 1'b1;
         end
         default: begin
            cls.grp = GROUP_RESET;
         end
      endcase
   end
endmodule : cwg_classify
`default_nettype wire

// File: rtl/cwg_top.sv
`timescale 1ns/100ps
`default_nettype none
module cwg_top (
   input  wire logic                        clk_in,
   input  wire logic                        srst_in,
   input  wire logic                        boot_load_in,
   input  wire logic [cwg_pkg::WORD_W-1:0]  nvm_lock_in,
   input  wire logic [cwg_pkg::WORD_W-1:0]  nvm_key_in,
   input  wire logic [cwg_pkg::CODE_W-1:0]  std_wp_in,
   input  wire logic                        cmd_valid_in,
   input  wire logic                        cmd_write_in,
   input  wire logic [cwg_pkg::CODE_W-1:0]  cmd_code_in,
   input  wire logic [cwg_pkg::WORD_W-1:0]  cmd_wdata_in,
   output logic                             cmd_done_out,
   output logic                             cmd_wr_ok_out,
   output logic                             cmd_cml_out,
   output logic                             cmd_rd_hit_out,
   output logic [cwg_pkg::WORD_W-1:0]       cmd_rdata_out,
   output logic [cwg_pkg::WORD_W-1:0]       lock_word_out,
   output logic [cwg_pkg::WORD_W-1:0]       key_word_out,
   output logic                             key_locked_out,
   output logic                             sealed_out,
   output logic                             save_all_go_out,
   output logic                             key_miss_out,
   output logic [cwg_pkg::GUARD_N-1:0]      group_ro_out
);
   import cwg_pkg::*;

   logic [WORD_W-1:0]   lock_word;
   logic [WORD_W-1:0]   key_word;
   logic [WORD_W-1:0]   boot_key;
   logic                save_boot_lock;
   cwg_key_state_t      key_state;

   logic                done;
   logic                wr_ok;
   logic                cml;
   logic                rd_hit;
   logic [WORD_W-1:0]   rdata;
   logic                save_go;
   logic                key_miss;

   logic [GUARD_N-1:0]  lock_ro;
   logic [GUARD_N-1:0]  group_ro;
   logic                std_wp_blocks;
   logic                key_locked;
   logic                is_write;
   logic                is_read;
   logic                grp_hit;
   logic                grp_refused;
   logic                fine_lock_refused;
   logic                key_matches;

   logic                next_wr_ok;
   logic                next_cml;
   logic                next_rd_hit;
   logic [WORD_W-1:0]   next_rdata;
   logic                next_save_go;
   logic                next_key_miss;

   cwg_class_if cls ();

   assign cls.code = cmd_code_in;

   cwg_classify u_classify (
      .cls (cls)
   );

   assign is_write   = cmd_valid_in & cmd_write_in;
   assign is_read    = cmd_valid_in & ~cmd_write_in;
   assign key_locked = (key_state != KEY_OPEN);

   // standard write protect: which codes stay writable at each setting
   always_comb begin
      case (std_wp_in)
         WP_ALL_BUT_WP: begin
            std_wp_blocks = (cmd_code_in != CMD_WRITE_PROTECT);
         end
         WP_ALL_BUT_RUN: begin
            std_wp_blocks = (cmd_code_in != CMD_WRITE_PROTECT) &&
                            (cmd_code_in != CMD_OPERATION) &&
                            (cmd_code_in != CMD_PAGE);
         end
         WP_ALL_BUT_LEVEL: begin
            std_wp_blocks = (cmd_code_in != CMD_WRITE_PROTECT) &&
                            (cmd_code_in != CMD_OPERATION) &&
                            (cmd_code_in != CMD_PAGE) &&
                            (cmd_code_in != CMD_ON_OFF_CONFIG) &&
                            (cmd_code_in != CMD_OUT_COMMAND);
         end
         default: begin
            std_wp_blocks = 1'b0;
         end
      endcase
   end

   // per-group read-only terms
   genvar g;
   generate
      for (g = 0; g < GUARD_N; g++) begin : g_guard
         if (g == GUARD_SAVE_ALL) begin : g_save
            // the value caught at boot or restore counts here, or-ed with the key lock
            assign lock_ro[g] = save_boot_lock | key_locked;
         end else begin : g_plain
            assign lock_ro[g] = lock_word[g];
         end
         assign group_ro[g] = lock_ro[g] | std_wp_blocks;
      end
   endgenerate

   assign grp_hit           = |cls.grp;
   assign grp_refused       = |(cls.grp & group_ro);
   assign fine_lock_refused = key_locked;
   assign key_matches       = (cmd_wdata_in == boot_key);

   // answer of the request, registered one cycle later
   always_comb begin
      next_wr_ok    = 1'b0;
      next_cml      = 1'b0;
      next_rd_hit   = 1'b0;
      next_rdata    = WORD_RESET;
      next_save_go  = 1'b0;
      next_key_miss = 1'b0;
      if (is_read) begin
         if (cls.is_ident) begin
            next_rd_hit = 1'b1;
            next_rdata  = IDENT_VALUE;
         end else if (cls.is_fine_lock) begin
            next_rd_hit = 1'b1;
            next_rdata  = lock_word;
         end
      end else if (is_write) begin
         if (cls.is_ident) begin
            // acknowledged, nothing stored, nothing flagged
            next_wr_ok = 1'b0;
            next_cml   = 1'b0;
         end else if (cls.is_fine_lock) begin
            next_wr_ok = ~fine_lock_refused;
            next_cml   = fine_lock_refused;
         end else if (cls.is_key) begin
            if (grp_refused) begin
               next_cml = 1'b1;
            end else if (key_locked) begin
               next_wr_ok    = key_matches;
               next_key_miss = ~key_matches;
               next_cml      = ~key_matches;
            end else begin
               next_wr_ok = 1'b1;
            end
         end else if (grp_hit) begin
            next_wr_ok   = ~grp_refused;
            next_cml     = grp_refused;
            next_save_go = cls.is_save_all & ~grp_refused;
         end else begin
            // codes outside these groups follow the standard protect only
            next_wr_ok = ~std_wp_blocks;
            next_cml   = std_wp_blocks;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         done     <= 1'b0;
         wr_ok    <= 1'b0;
         cml      <= 1'b0;
         rd_hit   <= 1'b0;
         rdata    <= WORD_RESET;
         save_go  <= 1'b0;
         key_miss <= 1'b0;
      end else begin
         done     <= cmd_valid_in;
         wr_ok    <= next_wr_ok;
         cml      <= next_cml;
         rd_hit   <= next_rd_hit;
         rdata    <= next_rdata;
         save_go  <= next_save_go;
         key_miss <= next_key_miss;
      end
   end

   // fine write lock word
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         lock_word <= WORD_RESET;
      end else if (boot_load_in) begin
         lock_word <= nvm_lock_in;
      end else if (is_write && cls.is_fine_lock && !fine_lock_refused) begin
         lock_word <= cmd_wdata_in;
      end
   end

   // save-all lock is only taken at boot or restore
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         save_boot_lock <= 1'b0;
      end else if (boot_load_in) begin
         save_boot_lock <= nvm_lock_in[GUARD_SAVE_ALL];
      end
   end

   // key value and the image caught at boot
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         key_word <= KEY_OPEN_VALUE;
         boot_key <= KEY_OPEN_VALUE;
      end else if (boot_load_in) begin
         key_word <= nvm_key_in;
         boot_key <= nvm_key_in;
      end else if (is_write && cls.is_key && !grp_refused && !key_locked) begin
         key_word <= cmd_wdata_in;
      end
   end

   // key state: open, shut by a nonzero boot key, or sealed for good
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         key_state <= KEY_OPEN;
      end else if (boot_load_in) begin
         if (nvm_key_in == KEY_OPEN_VALUE) begin
            key_state <= KEY_OPEN;
         end else if (nvm_lock_in[GUARD_KEY]) begin
            // key can never be written again, so the lock word stays shut
            key_state <= KEY_SEALED;
         end else begin
            key_state <= KEY_SHUT;
         end
      end else begin
         case (key_state)
            KEY_OPEN: begin
               if (next_save_go && lock_word[GUARD_KEY] && key_word != KEY_OPEN_VALUE) begin
                  key_state <= KEY_SEALED;
               end
            end
            KEY_SHUT: begin
               if (is_write && cls.is_key && !grp_refused && key_matches) begin
                  key_state <= KEY_OPEN;
               end
            end
            KEY_SEALED: begin
               key_state <= KEY_SEALED;
            end
            default: begin
               key_state <= KEY_SEALED;
            end
         endcase
      end
   end

   assign cmd_done_out    = done;
   assign cmd_wr_ok_out   = wr_ok;
   assign cmd_cml_out     = cml;
   assign cmd_rd_hit_out  = rd_hit;
   assign cmd_rdata_out   = rdata;
   assign lock_word_out   = lock_word;
   assign key_word_out    = key_word;
   assign key_locked_out  = key_locked;
   assign sealed_out      = (key_state == KEY_SEALED);
   assign save_all_go_out = save_go;
   assign key_miss_out    = key_miss;
   assign group_ro_out    = group_ro;
endmodule : cwg_top
`default_nettype wire

// File: tb/cwg_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module cwg_top_monitor (
   input wire logic                       clk_in,
   input wire logic                       srst_in,
   input wire logic                       boot_load_in,
   input wire logic [cwg_pkg::CODE_W-1:0] std_wp_in,
   input wire logic                       cmd_valid_in,
   input wire logic                       cmd_write_in,
   input wire logic [cwg_pkg::CODE_W-1:0] cmd_code_in,
   input wire logic                       cmd_done_out,
   input wire logic                       cmd_wr_ok_out,
   input wire logic                       cmd_cml_out,
   input wire logic                       cmd_rd_hit_out,
   input wire logic [cwg_pkg::WORD_W-1:0] cmd_rdata_out,
   input wire logic [cwg_pkg::WORD_W-1:0] lock_word_out,
   input wire logic                       key_locked_out,
   input wire logic                       sealed_out,
   input wire logic                       save_all_go_out
);
   import cwg_pkg::*;
   logic wr;
   logic rd;
   assign wr = cmd_valid_in && cmd_write_in;
   assign rd = cmd_valid_in && !cmd_write_in;
   default clocking mon_cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   a_answer_once: assert property ($past(srst_in) || cmd_done_out == $past(cmd_valid_in))
      else $error("answer not exactly one cycle after request");
   a_ident_read: assert property (rd && cmd_code_in == CMD_PLATFORM_IDENT |=> cmd_rd_hit_out && cmd_rdata_out == IDENT_VALUE)
      else $error("ident read wrong");
   a_ident_write: assert property (wr && cmd_code_in == CMD_PLATFORM_IDENT |=> cmd_done_out && !cmd_wr_ok_out && !cmd_cml_out)
      else $error("ident write not silently discarded");
   a_run_locked: assert property (wr && cmd_code_in == CMD_OPERATION && lock_word_out[GUARD_RUN_COMMAND] |=> cmd_cml_out && !cmd_wr_ok_out)
      else $error("locked operation write accepted");
   a_margin_open: assert property (wr && cmd_code_in == CMD_MARGIN_HIGH && !lock_word_out[GUARD_LEVEL_SHIFT] && std_wp_in == 8'h00 |=> cmd_wr_ok_out)
      else $error("open margin write refused");
   a_key_locked: assert property (wr && cmd_code_in == CMD_KEY && lock_word_out[GUARD_KEY] |=> cmd_cml_out && !cmd_wr_ok_out)
      else $error("key write accepted under lock bit");
   a_seal_refuse: assert property (wr && cmd_code_in == CMD_FINE_LOCK && sealed_out |=> cmd_cml_out && !cmd_wr_ok_out)
      else $error("lock word written while sealed");
   a_shut_save: assert property (wr && cmd_code_in == CMD_STORE_ALL && key_locked_out |=> cmd_cml_out && !save_all_go_out)
      else $error("store-all accepted with key shut");
   a_save_cause: assert property (save_all_go_out |-> cmd_wr_ok_out && $past(wr) && $past(cmd_code_in) == CMD_STORE_ALL)
      else $error("store-all without its request");
   a_lock_hold: assert property (!$stable(lock_word_out) |-> $past(srst_in) || $past(boot_load_in)
      || cmd_wr_ok_out && $past(wr) && $past(cmd_code_in) == CMD_FINE_LOCK)
      else $error("lock word changed without accepted write");
endmodule // cwg_top_monitor

bind cwg_top cwg_top_monitor u_mon (.clk_in, .srst_in, .boot_load_in, .std_wp_in, .cmd_valid_in, .cmd_write_in,
   .cmd_code_in, .cmd_done_out, .cmd_wr_ok_out, .cmd_cml_out, .cmd_rd_hit_out, .cmd_rdata_out, .lock_word_out,
   .key_locked_out, .sealed_out, .save_all_go_out);
`default_nettype wire

// File: tb/cwg_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// bus host: one word request per call, answer taken mid-cycle while it stands after the taking edge
module cwg_host_model (
   input  wire logic        clk_in,
   output logic             valid_out,
   output logic             write_out,
   output logic [7:0]       code_out,
   output logic [15:0]      wdata_out,
   input  wire logic [5:0]  flags_in,
   input  wire logic [15:0] rdata_in
);
   logic [5:0]  flags;
   logic [15:0] rdata;

   initial begin
      valid_out = 1'b0;
      write_out = 1'b0;
      code_out  = 8'h00;
      wdata_out = 16'h0000;
   end

   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(posedge clk_in);
      valid_out <= 1'b1;
      write_out <= w;
      code_out  <= c;
      wdata_out <= d;
      @(posedge clk_in);
      // released lines must not keep their last value
      valid_out <= 1'b0;
      write_out <= ~w;
      code_out  <= ~c;
      wdata_out <= ~d;
      // the answer is launched at the taking edge and stands until the next rising edge
      @(negedge clk_in);
      flags = flags_in;
      rdata = rdata_in;
      @(posedge clk_in);
   endtask
endmodule // cwg_host_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cwg_pkg::*;
   // answer flags: done, ok, cml, hit, go, miss
   localparam logic [5:0] F_OK   = 6'h30;
   localparam logic [5:0] F_REF  = 6'h28;
   localparam logic [5:0] F_HIT  = 6'h24;
   localparam logic [5:0] F_ACK  = 6'h20;
   localparam logic [5:0] F_GO   = 6'h32;
   localparam logic [5:0] F_MISS = 6'h29;
   // command codes grouped by lock bit, bit 9 first
   localparam logic [7:0] GCODE [38] = '{8'h46, 8'h47, 8'h4F, 8'h50, 8'hD0, 8'h25, 8'h26, 8'h27, 8'h01,
      8'h33, 8'h37, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hD8, 8'h58, 8'h55, 8'h57, 8'h56,
      8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h02, 8'h35, 8'h36, 8'h99, 8'h9A, 8'h9B, 8'h9E, 8'hD9, 8'hDA};
   localparam int         GCOUNT [8] = '{5, 3, 1, 10, 4, 9, 4, 2};

   logic              clk_in, srst_in, boot_load_in;
   logic [WORD_W-1:0] nvm_lock_in, nvm_key_in, cmd_wdata_in, cmd_rdata_out, lock_word_out, key_word_out;
   logic [CODE_W-1:0] std_wp_in, cmd_code_in;
   logic              cmd_valid_in, cmd_write_in, cmd_done_out, cmd_wr_ok_out, cmd_cml_out, cmd_rd_hit_out;
   logic              key_locked_out, sealed_out, save_all_go_out, key_miss_out;
   logic [5:0]        flags;
   logic [GUARD_N-1:0] group_ro_out;
   int                n_errors, tests_run;

   assign flags = {cmd_done_out, cmd_wr_ok_out, cmd_cml_out, cmd_rd_hit_out, save_all_go_out, key_miss_out};

   cwg_top dut (.clk_in, .srst_in, .boot_load_in, .nvm_lock_in, .nvm_key_in, .std_wp_in, .cmd_valid_in,
      .cmd_write_in, .cmd_code_in, .cmd_wdata_in, .cmd_done_out, .cmd_wr_ok_out, .cmd_cml_out, .cmd_rd_hit_out,
      .cmd_rdata_out, .lock_word_out, .key_word_out, .key_locked_out, .sealed_out, .save_all_go_out,
      .key_miss_out, .group_ro_out);
   cwg_host_model host (.clk_in, .valid_out(cmd_valid_in), .write_out(cmd_write_in), .code_out(cmd_code_in),
      .wdata_out(cmd_wdata_in), .flags_in(flags), .rdata_in(cmd_rdata_out));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic close_out;
      $display("%0d mismatches in %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk_f(input logic [5:0] exp);
      tests_run++;
      if (host.flags !== exp) begin
         n_errors++;
         $display("MISMATCH %0t flags %b expected %b", $time, host.flags, exp);
      end
   endtask

   task automatic chk_w(input logic [15:0] act, input logic [15:0] exp);
      tests_run++;
      if (act !== exp) begin
         n_errors++;
         $display("MISMATCH %0t word %h expected %h", $time, act, exp);
      end
   endtask

   task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [5:0] exp);
      host.xfer(w, c, d);
      chk_f(exp);
   endtask

   task automatic boot(input logic [15:0] lk, input logic [15:0] ky);
      @(posedge clk_in);
      boot_load_in <= 1'b1;
      nvm_lock_in  <= lk;
      nvm_key_in   <= ky;
      @(posedge clk_in);
      boot_load_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic t_ident;
      boot(WORD_RESET, KEY_OPEN_VALUE);
      op(1'b0, CMD_PLATFORM_IDENT, 16'h0000, F_HIT);
      chk_w(host.rdata, IDENT_VALUE);
      op(1'b1, CMD_PLATFORM_IDENT, ~IDENT_VALUE, F_ACK);
      op(1'b0, CMD_PLATFORM_IDENT, 16'h0000, F_HIT);
      chk_w(host.rdata, IDENT_VALUE);
   endtask

   task automatic t_groups;
      int k;
      boot(WORD_RESET, KEY_OPEN_VALUE);
      // b picks the single lock bit set, b of 8 leaves every group open
      for (int b = 0; b <= 8; b++) begin
         op(1'b1, CMD_FINE_LOCK, (b < 8) ? (16'h0200 >> b) : 16'h0000, F_OK);
         k = 0;
         for (int g = 0; g < 8; g++) begin
            for (int j = 0; j < GCOUNT[g]; j++) begin
               op(1'b1, GCODE[k], 16'h00C3, (g == b) ? F_REF : F_OK);
               k++;
            end
         end
      end
   endtask

   task automatic t_std_wp;
      std_wp_in <= WP_ALL_BUT_WP;
      op(1'b1, CMD_OPERATION, 16'h0080, F_REF);
      std_wp_in <= WP_ALL_BUT_RUN;
      op(1'b1, CMD_OPERATION, 16'h0080, F_OK);
      op(1'b1, CMD_ON_OFF_CONFIG, 16'h0017, F_REF);
      std_wp_in <= WP_ALL_BUT_LEVEL;
      op(1'b1, CMD_ON_OFF_CONFIG, 16'h0017, F_OK);
      op(1'b1, CMD_BUS_ADDRESS, 16'h0024, F_REF);
      std_wp_in <= 8'h00;
   endtask

   task automatic t_key;
      boot(16'h0002, KEY_OPEN_VALUE);
      op(1'b1, CMD_KEY, 16'h00AB, F_REF);
      chk_w(key_word_out, 16'h0000);
      chk_w({6'h00, group_ro_out}, 16'h0002);
      boot(16'h0000, 16'h1234);
      chk_w({15'h0000, key_locked_out}, 16'h0001);
      op(1'b1, CMD_STORE_ALL, 16'h0000, F_REF);
      op(1'b1, CMD_FINE_LOCK, 16'h0080, F_REF);
      chk_w(lock_word_out, 16'h0000);
      op(1'b1, CMD_KEY, 16'h1235, F_MISS);
      op(1'b1, CMD_KEY, 16'h1234, F_OK);
      op(1'b1, CMD_FINE_LOCK, 16'h0080, F_OK);
      chk_w(lock_word_out, 16'h0080);
      op(1'b1, CMD_OPERATION, 16'h0000, F_REF);
   endtask

   task automatic t_save;
      boot(16'h0001, KEY_OPEN_VALUE);
      op(1'b1, CMD_STORE_ALL, 16'h0000, F_REF);
      op(1'b1, CMD_FINE_LOCK, 16'h0000, F_OK);
      op(1'b1, CMD_STORE_ALL, 16'h0000, F_REF);
      boot(WORD_RESET, KEY_OPEN_VALUE);
      op(1'b1, CMD_STORE_ALL, 16'h0000, F_GO);
      op(1'b1, CMD_KEY, 16'h00AB, F_OK);
      chk_w(key_word_out, 16'h00AB);
      op(1'b1, CMD_FINE_LOCK, 16'h0002, F_OK);
      op(1'b1, CMD_STORE_ALL, 16'h0000, F_GO);
      chk_w({15'h0000, sealed_out}, 16'h0001);
      op(1'b1, CMD_FINE_LOCK, 16'h0000, F_REF);
      chk_w(lock_word_out, 16'h0002);
   endtask

   task automatic t_seal;
      srst_in <= 1'b1;
      repeat (16) @(posedge clk_in);
      srst_in <= 1'b0;
      boot(16'h0002, 16'h0005);
      chk_w({15'h0000, sealed_out}, 16'h0001);
      op(1'b1, CMD_FINE_LOCK, 16'h0000, F_REF);
   endtask

   // the whole run needs about 1180 cycles
   initial begin
      repeat (20000) @(posedge clk_in);
      n_errors++;
      close_out();
   end

   initial begin
      n_errors = 0;
      tests_run = 0;
      srst_in = 1'b1;
      boot_load_in = 1'b0;
      nvm_lock_in = WORD_RESET;
      nvm_key_in = KEY_OPEN_VALUE;
      std_wp_in = 8'h00;
      repeat (16) @(posedge clk_in);
      srst_in <= 1'b0;
      t_ident();
      t_groups();
      t_std_wp();
      t_key();
      t_save();
      t_seal();
      close_out();
   end
endmodule // tb_top
`default_nettype wire
